// ==== btd_defs.vh ====
// constants for the byte transfer instruction decoder
`ifndef BTD_DEFS_VH
`define BTD_DEFS_VH
// operation codes on insn_op
`define BTD_OP_MOV_R_IMM 4'h0
`define BTD_OP_MOV_A_R 4'h1
`define BTD_OP_MOV_R_A 4'h2
`define BTD_OP_MOV_A_M 4'h3
`define BTD_OP_MOV_M_A 4'h4
`define BTD_OP_MOV_M_IMM 4'h5
`define BTD_OP_MOV_PSW_IMM 4'h6
`define BTD_OP_MOV_A_PSW 4'h7
`define BTD_OP_MOV_PSW_A 4'h8
`define BTD_OP_XCH_A_R 4'h9
`define BTD_OP_XCH_A_M 4'ha
`define BTD_OP_SEL_BANK 4'hb
`define BTD_OP_CALL_PAGE 4'hc
`define BTD_OP_VECTOR 4'hd
`define BTD_OP_REL 4'he
// memory addressing modes on insn_mode
`define BTD_MD_SADDR 3'h0
`define BTD_MD_SFR 3'h1
`define BTD_MD_ABS 3'h2
`define BTD_MD_DE 3'h3
`define BTD_MD_HL 3'h4
`define BTD_MD_HL_BYTE 3'h5
`define BTD_MD_HL_B 3'h6
`define BTD_MD_HL_C 3'h7
// absolute register and pair numbers
`define BTD_R_X 3'h0
`define BTD_R_A 3'h1
`define BTD_R_C 3'h2
`define BTD_R_B 3'h3
`define BTD_R_E 3'h4
`define BTD_R_D 3'h5
`define BTD_R_L 3'h6
`define BTD_R_H 3'h7
`define BTD_RP_AX 2'h0
`define BTD_RP_HL 2'h3
// address windows
`define BTD_SADDR_BASE 16'hfe20
`define BTD_SADDR_LAST 16'hff1f
`define BTD_SFR_BASE 16'hff00
`define BTD_SFR_HOLE_LO 16'hffd0
`define BTD_SFR_HOLE_HI 16'hffdf
`define BTD_CALL_PAGE_BASE 16'h0800
`define BTD_VECTOR_BASE 16'h0040
`define BTD_HSRAM_LO 16'hfb00
`define BTD_HSRAM_HI 16'hfeff
// flag positions and reset value of the program status word
`define BTD_PSW_Z 6
`define BTD_PSW_AC 4
`define BTD_PSW_CY 0
`define BTD_PSW_RST 8'h02
// clocks for operations outside the transfer table
`define BTD_CALC_CLKS 4'h2
`endif

// ==== btd_core.v ====
// byte transfer instruction decoder and executor
`timescale 1ns/100ps
`default_nettype none
`include "btd_defs.vh"
module btd_core (
	input wire clk,
	input wire sys_rst,
	input wire insn_valid,
	input wire [3:0] insn_op,
	input wire [2:0] insn_mode,
	input wire [2:0] insn_reg,
	input wire insn_pair,
	input wire [15:0] insn_addr,
	input wire [7:0] insn_byte,
	input wire [7:0] mem_rdata,
	input wire [2:0] peek_sel,
	output reg insn_ready,
	output reg done,
	output reg illegal,
	output reg [1:0] insn_len,
	output reg mem_rd,
	output reg mem_wr,
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg [7:0] acc,
	output reg [15:0] word_acc,
	output reg [7:0] program_status_word,
	output reg [1:0] register_bank_number,
	output reg [15:0] target_addr,
	output reg [7:0] peek_data
);

	// four banks of eight byte registers
	reg [7:0] gpr [0:31];
	reg [3:0] cnt;
	reg [3:0] cur_op;
	reg [2:0] cur_reg;
	reg [7:0] cur_byte;
	reg [15:0] cur_tgt;
	reg cur_bad;
	reg rd_pend;
	reg [7:0] rd_data;
	integer i;

	wire [4:0] bsel = {register_bank_number, 3'h0};
	wire [7:0] reg_a = gpr[bsel | {2'h0, `BTD_R_A}];
	wire [7:0] reg_r = gpr[bsel | {2'h0, insn_reg}];
	wire [15:0] pair_hl = {gpr[bsel | {2'h0, `BTD_R_H}], gpr[bsel | {2'h0, `BTD_R_L}]};
	wire [15:0] pair_de = {gpr[bsel | {2'h0, `BTD_R_D}], gpr[bsel | {2'h0, `BTD_R_E}]};
	wire [7:0] reg_b = gpr[bsel | {2'h0, `BTD_R_B}];
	wire [7:0] reg_c = gpr[bsel | {2'h0, `BTD_R_C}];
	wire accept = insn_valid & insn_ready;

	// effective address of the memory operand
	reg [15:0] ea;
	always @* begin
		case (insn_mode)
			`BTD_MD_SADDR: ea = `BTD_SADDR_BASE + {8'h00, insn_addr[7:0]};
			`BTD_MD_SFR: ea = `BTD_SFR_BASE | {8'h00, insn_addr[7:0]};
			`BTD_MD_ABS: ea = insn_addr;
			`BTD_MD_DE: ea = pair_de;
			`BTD_MD_HL: ea = pair_hl;
			`BTD_MD_HL_BYTE: ea = pair_hl + {8'h00, insn_byte};
			`BTD_MD_HL_B: ea = pair_hl + {8'h00, reg_b};
			`BTD_MD_HL_C: ea = pair_hl + {8'h00, reg_c};
			default: ea = 16'h0000;
		endcase
	end

	// operand legality; a refused operand retires as a no-op with illegal set
	wire is_mem = (insn_op == `BTD_OP_MOV_A_M) | (insn_op == `BTD_OP_MOV_M_A) |
		(insn_op == `BTD_OP_MOV_M_IMM) | (insn_op == `BTD_OP_XCH_A_M);
	wire sfr_hole = (insn_mode == `BTD_MD_SFR) & (ea >= `BTD_SFR_HOLE_LO) & (ea <= `BTD_SFR_HOLE_HI);
	wire sad_over = (insn_mode == `BTD_MD_SADDR) & (ea > `BTD_SADDR_LAST);
	wire pair_odd = insn_pair & ea[0] & (insn_mode <= `BTD_MD_ABS);
	wire imm_mode = (insn_mode == `BTD_MD_SADDR) | (insn_mode == `BTD_MD_SFR);
	wire bad = (is_mem & (sfr_hole | sad_over | pair_odd)) |
		((insn_op == `BTD_OP_MOV_M_IMM) & ~imm_mode) | (insn_op > `BTD_OP_REL);
	// high-speed RAM or no data access picks the short count
	wire fast = ~is_mem | ((ea >= `BTD_HSRAM_LO) & (ea <= `BTD_HSRAM_HI));

	// clocks per instruction: short count, long count
	reg [3:0] c_fast;
	reg [3:0] c_slow;
	reg [1:0] len;
	always @* begin
		c_fast = `BTD_CALC_CLKS;
		c_slow = `BTD_CALC_CLKS;
		len = 2'h2;
		case (insn_op)
			`BTD_OP_MOV_R_IMM: begin
				c_fast = 4'h4;
				c_slow = 4'h4;
			end
			`BTD_OP_MOV_A_R, `BTD_OP_MOV_R_A, `BTD_OP_XCH_A_R: begin
				c_fast = 4'h2;
				c_slow = 4'h2;
				len = 2'h1;
			end
			`BTD_OP_MOV_M_IMM: begin
				c_fast = (insn_mode == `BTD_MD_SFR) ? 4'h7 : 4'h6;
				c_slow = 4'h7;
				len = 2'h3;
			end
			`BTD_OP_MOV_PSW_IMM: begin
				c_fast = 4'h7;
				c_slow = 4'h7;
				len = 2'h3;
			end
			`BTD_OP_MOV_A_PSW, `BTD_OP_MOV_PSW_A: begin
				c_fast = 4'h5;
				c_slow = 4'h5;
			end
			`BTD_OP_MOV_A_M, `BTD_OP_MOV_M_A: begin
				case (insn_mode)
					`BTD_MD_SADDR: begin
						c_fast = 4'h4;
						c_slow = 4'h5;
					end
					`BTD_MD_SFR: begin
						c_fast = 4'h5;
						c_slow = 4'h5;
					end
					`BTD_MD_ABS, `BTD_MD_HL_BYTE: begin
						c_fast = 4'h8;
						c_slow = 4'h9;
						len = (insn_mode == `BTD_MD_ABS) ? 2'h3 : 2'h2;
					end
					`BTD_MD_HL_B, `BTD_MD_HL_C: begin
						c_fast = 4'h6;
						c_slow = 4'h7;
						len = 2'h1;
					end
					default: begin
						c_fast = 4'h4;
						c_slow = 4'h5;
						len = 2'h1;
					end
				endcase
			end
			`BTD_OP_XCH_A_M: begin
				case (insn_mode)
					`BTD_MD_SADDR: begin
						c_fast = 4'h4;
						c_slow = 4'h6;
					end
					`BTD_MD_SFR: begin
						c_fast = 4'h6;
						c_slow = 4'h6;
					end
					`BTD_MD_DE, `BTD_MD_HL: begin
						c_fast = 4'h4;
						c_slow = 4'h6;
						len = 2'h1;
					end
					default: begin
						c_fast = 4'h8;
						c_slow = 4'ha;
						len = (insn_mode == `BTD_MD_ABS) ? 2'h3 : 2'h2;
					end
				endcase
			end
			default: begin
				c_fast = `BTD_CALC_CLKS;
				c_slow = `BTD_CALC_CLKS;
			end
		endcase
	end

	// branch and table targets computed at accept
	reg [15:0] next_tgt;
	always @* begin
		case (insn_op)
			`BTD_OP_CALL_PAGE: next_tgt = `BTD_CALL_PAGE_BASE | {5'h00, insn_addr[10:0]};
			`BTD_OP_VECTOR: next_tgt = `BTD_VECTOR_BASE | {10'h000, insn_addr[4:0], 1'b0};
			`BTD_OP_REL: next_tgt = insn_addr + {{8{insn_byte[7]}}, insn_byte};
			default: next_tgt = ea;
		endcase
	end

	// sequencer: one count per clk edge, so counts are cpu clocks
	always @(posedge clk) begin
		if (sys_rst) begin
			insn_ready <= 1'b1;
			done <= 1'b0;
			illegal <= 1'b0;
			insn_len <= 2'h0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			program_status_word <= `BTD_PSW_RST;
			register_bank_number <= 2'h0;
			target_addr <= 16'h0000;
			cnt <= 4'h0;
			cur_op <= 4'h0;
			cur_reg <= 3'h0;
			cur_byte <= 8'h00;
			cur_tgt <= 16'h0000;
			cur_bad <= 1'b0;
			rd_pend <= 1'b0;
			rd_data <= 8'h00;
			for (i = 0; i < 32; i = i + 1) begin
				gpr[i] <= 8'h00;
			end
		end else begin
			done <= 1'b0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			rd_pend <= mem_rd;
			if (rd_pend) begin
				rd_data <= mem_rdata;
			end
			if (accept) begin
				insn_ready <= 1'b0;
				// refused operands retire after the short calc count, with no data access
				cnt <= bad ? (`BTD_CALC_CLKS - 4'h1) : ((fast ? c_fast : c_slow) - 4'h1);
				cur_op <= insn_op;
				cur_reg <= insn_reg;
				cur_byte <= insn_byte;
				cur_tgt <= next_tgt;
				cur_bad <= bad;
				insn_len <= len;
				mem_addr <= ea;
				// loads and exchanges fetch now; data lands two edges later
				if (~bad & ((insn_op == `BTD_OP_MOV_A_M) | (insn_op == `BTD_OP_XCH_A_M))) begin
					mem_rd <= 1'b1;
				end
			end else if (~insn_ready) begin
				cnt <= cnt - 4'h1;
				if (cnt == 4'h1) begin
					// commit all effects in one edge so no half state is seen
					insn_ready <= 1'b1;
					done <= 1'b1;
					illegal <= cur_bad;
					if (~cur_bad) begin
						case (cur_op)
							`BTD_OP_MOV_R_IMM: gpr[bsel | {2'h0, cur_reg}] <= cur_byte;
							`BTD_OP_MOV_A_R: gpr[bsel | {2'h0, `BTD_R_A}] <= gpr[bsel | {2'h0, cur_reg}];
							`BTD_OP_MOV_R_A: gpr[bsel | {2'h0, cur_reg}] <= gpr[bsel | {2'h0, `BTD_R_A}];
							`BTD_OP_MOV_A_M: gpr[bsel | {2'h0, `BTD_R_A}] <= rd_data;
							`BTD_OP_MOV_M_A: begin
								mem_wr <= 1'b1;
								mem_wdata <= gpr[bsel | {2'h0, `BTD_R_A}];
							end
							`BTD_OP_MOV_M_IMM: begin
								mem_wr <= 1'b1;
								mem_wdata <= cur_byte;
							end
							`BTD_OP_MOV_PSW_IMM: program_status_word <= cur_byte;
							`BTD_OP_MOV_A_PSW: gpr[bsel | {2'h0, `BTD_R_A}] <= program_status_word;
							`BTD_OP_MOV_PSW_A: program_status_word <= gpr[bsel | {2'h0, `BTD_R_A}];
							`BTD_OP_XCH_A_R: begin
								gpr[bsel | {2'h0, `BTD_R_A}] <= gpr[bsel | {2'h0, cur_reg}];
								gpr[bsel | {2'h0, cur_reg}] <= gpr[bsel | {2'h0, `BTD_R_A}];
							end
							`BTD_OP_XCH_A_M: begin
								gpr[bsel | {2'h0, `BTD_R_A}] <= rd_data;
								mem_wr <= 1'b1;
								mem_wdata <= gpr[bsel | {2'h0, `BTD_R_A}];
							end
							`BTD_OP_SEL_BANK: register_bank_number <= cur_byte[1:0];
							default: target_addr <= cur_tgt;
						endcase
					end
				end
			end
		end
	end

	// accumulator views and register peek, refreshed every edge
	always @(posedge clk) begin
		if (sys_rst) begin
			acc <= 8'h00;
			word_acc <= 16'h0000;
			peek_data <= 8'h00;
		end else begin
			acc <= reg_a;
			word_acc <= {gpr[bsel | {2'h0, `BTD_R_A}], gpr[bsel | {2'h0, `BTD_R_X}]};
			peek_data <= gpr[bsel | {2'h0, peek_sel}];
		end
	end

	wire unused_ok = &{1'b0, reg_r, `BTD_RP_AX, `BTD_RP_HL};

endmodule // btd_core
`default_nettype wire

// ==== btd_chk.sv ====
// assertion checker for the byte transfer decoder
`timescale 1ns/100ps
`default_nettype none
`include "btd_defs.vh"
module btd_chk (
	input wire clk,
	input wire sys_rst,
	input wire insn_valid,
	input wire insn_ready,
	input wire [3:0] insn_op,
	input wire [2:0] insn_mode,
	input wire insn_pair,
	input wire [15:0] insn_addr,
	input wire done,
	input wire illegal,
	input wire mem_rd,
	input wire mem_wr,
	input wire [15:0] mem_addr
);
	wire take;
	wire load;
	// accepted request, and the memory load form of it
	assign take = insn_valid && insn_ready;
	assign load = take && insn_op == `BTD_OP_MOV_A_M;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_accept_busy: assert property (take |=> !insn_ready)
		else $error("ready stayed high after accept");
	a_done_single: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_wr_with_done: assert property (mem_wr |-> done && !illegal)
		else $error("write apart from retirement");
	a_rd_while_busy: assert property (mem_rd |-> !insn_ready)
		else $error("read strobe while idle");
	a_sfr_hole: assert property (load && insn_mode == `BTD_MD_SFR && insn_addr[7:4] == 4'hd |-> ##2 done && illegal)
		else $error("special register hole not refused");
	a_odd_pair: assert property (load && insn_mode == `BTD_MD_SADDR && insn_pair && insn_addr[0] |-> ##2 done && illegal)
		else $error("odd pair address not refused");
	a_short_addr: assert property (load && insn_mode == `BTD_MD_SADDR && !insn_pair |->
		##2 mem_addr == 16'hfe20 + $past(insn_addr[7:0], 2)) else $error("short direct address wrong");
	a_fast_count: assert property (load && insn_mode == `BTD_MD_HL_B ##2 (mem_addr >= 16'hfb00 && mem_addr <= 16'hfeff)
		|-> !done[*4] ##1 done) else $error("six clock count missed");
	c_refused: cover property (done && illegal);
	c_store: cover property (mem_wr);
	c_load: cover property (mem_rd);
endmodule // btd_chk
bind btd_core btd_chk u_chk (.clk, .sys_rst, .insn_valid, .insn_ready, .insn_op, .insn_mode, .insn_pair,
	.insn_addr, .done, .illegal, .mem_rd, .mem_wr, .mem_addr);
`default_nettype wire

// ==== tb_byte_transfer_insn_decode.sv ====
// self-checking testbench for the byte transfer decoder
`timescale 1ns/100ps
`default_nettype none
`include "btd_defs.vh"
module tb_byte_transfer_insn_decode;
	reg clk = 0, sys_rst = 1, insn_valid = 0, insn_pair = 0, wr;
	reg [3:0] insn_op = 0;
	reg [2:0] insn_mode = 0, insn_reg = 0, peek_sel = `BTD_R_A;
	reg [15:0] insn_addr = 0;
	reg [7:0] insn_byte = 0, mem_rdata = 0;
	wire insn_ready, done, illegal, mem_rd, mem_wr;
	wire [1:0] insn_len, register_bank_number;
	wire [15:0] mem_addr, word_acc, target_addr;
	wire [7:0] mem_wdata, acc, program_status_word, peek_data;
	integer errors = 0, checks = 0, cyc, i;
	btd_core uut (.clk, .sys_rst, .insn_valid, .insn_op, .insn_mode, .insn_reg, .insn_pair, .insn_addr,
		.insn_byte, .mem_rdata, .peek_sel, .insn_ready, .done, .illegal, .insn_len, .mem_rd, .mem_wr,
		.mem_addr, .mem_wdata, .acc, .word_acc, .program_status_word, .register_bank_number,
		.target_addr, .peek_data);
	// 50 ns cpu clock
	always #25 clk = ~clk;
	task close_out;
	begin
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task chk(input [15:0] g, input [15:0] e);
	begin
		checks = checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	end
	endtask
	// one instruction, counting clocks to retirement; a hang ends the run
	task run(input [3:0] o, input [2:0] m, input [2:0] r, input p, input [15:0] a, input [7:0] b);
	begin
		insn_op = o;
		insn_mode = m;
		insn_reg = r;
		insn_pair = p;
		insn_addr = a;
		insn_byte = b;
		insn_valid = 1;
		@(negedge clk);
		insn_valid = 0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 40) begin
			@(negedge clk);
			cyc = cyc + 1;
		end
		wr = mem_wr;
		if (cyc >= 40) begin
			errors = errors + 1;
			close_out;
		end
		@(negedge clk);
	end
	endtask
	task t_regs;
	begin
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_A, 0, 0, 8'h5a);
		chk(cyc[15:0], 16'h0004);
		chk(acc, 8'h5a);
		chk(peek_data, 8'h5a);
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_X, 0, 0, 8'h3c);
		chk(word_acc, 16'h5a3c);
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_C, 0, 0, 8'h20);
		run(`BTD_OP_MOV_A_R, 0, `BTD_R_C, 0, 0, 0);
		chk({cyc[3:0], 2'h0, insn_len, acc}, 16'h2120);
		run(`BTD_OP_XCH_A_R, 0, `BTD_R_X, 0, 0, 0);
		chk({cyc[3:0], 2'h0, insn_len, 8'h00}, 16'h2100);
		chk(word_acc, 16'h3c20);
	end
	endtask
	task t_flags;
	begin
		chk(program_status_word, 8'h02);
		run(`BTD_OP_MOV_PSW_IMM, 0, 0, 0, 0, 8'h51);
		chk(program_status_word, 8'h51);
		run(`BTD_OP_MOV_A_PSW, 0, 0, 0, 0, 0);
		chk({cyc[3:0], 4'h0, acc}, 16'h5051);
		chk(program_status_word, 8'h51);
		run(`BTD_OP_MOV_A_R, 0, `BTD_R_X, 0, 0, 0);
		chk(program_status_word, 8'h51);
		run(`BTD_OP_MOV_PSW_A, 0, 0, 0, 0, 0);
		chk(program_status_word, 8'h20);
	end
	endtask
	task t_index;
	begin
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_H, 0, 0, 8'hfc);
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_L, 0, 0, 8'h00);
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_B, 0, 0, 8'h10);
		mem_rdata = 8'h99;
		run(`BTD_OP_MOV_A_M, `BTD_MD_HL_B, 0, 0, 0, 0);
		chk({cyc[3:0], 2'h0, insn_len, acc}, 16'h6199);
		chk(mem_addr, 16'hfc10);
		mem_rdata = 8'h44;
		run(`BTD_OP_XCH_A_M, `BTD_MD_HL_BYTE, 0, 0, 0, 8'h05);
		chk({cyc[3:0], 2'h0, insn_len, mem_wdata}, 16'h8299);
		chk(wr, 1);
		chk(acc, 8'h44);
		run(`BTD_OP_MOV_R_IMM, 0, `BTD_R_H, 0, 0, 8'h80);
		run(`BTD_OP_XCH_A_M, `BTD_MD_HL_BYTE, 0, 0, 0, 8'h05);
		chk({cyc[3:0], mem_wdata}, 16'ha44);
		run(`BTD_OP_MOV_M_A, `BTD_MD_HL_C, 0, 0, 0, 0);
		chk({cyc[3:0], 2'h0, insn_len, mem_wdata}, 16'h7144);
		chk(wr, 1);
		chk(mem_addr, 16'h8020);
	end
	endtask
	task t_refuse;
	begin
		run(`BTD_OP_MOV_A_M, `BTD_MD_SFR, 0, 0, 16'h00d0, 0);
		chk({cyc[3:0], illegal}, 16'h5);
		run(`BTD_OP_MOV_A_M, `BTD_MD_SFR, 0, 0, 16'h00df, 0);
		chk(illegal, 1);
		run(`BTD_OP_MOV_A_M, `BTD_MD_SFR, 0, 0, 16'h00e0, 0);
		chk(illegal, 0);
		chk(mem_addr, 16'hffe0);
		run(`BTD_OP_MOV_A_M, `BTD_MD_SADDR, 0, 1, 16'h0001, 0);
		chk(illegal, 1);
		run(`BTD_OP_MOV_A_M, `BTD_MD_SADDR, 0, 0, 16'h00ff, 0);
		chk(illegal, 0);
		chk(mem_addr, 16'hff1f);
		run(`BTD_OP_MOV_M_IMM, `BTD_MD_SADDR, 0, 0, 16'h0010, 8'h77);
		chk({cyc[3:0], 2'h0, insn_len, mem_wdata}, 16'h6377);
		chk(mem_addr, 16'hfe30);
		chk(wr, 1);
		run(`BTD_OP_MOV_M_IMM, `BTD_MD_HL, 0, 0, 0, 8'h77);
		chk({cyc[3:0], illegal, wr}, 16'h000a);
	end
	endtask
	task t_targets;
	begin
		run(`BTD_OP_CALL_PAGE, 0, 0, 0, 16'h07ff, 0);
		chk(target_addr, 16'h0fff);
		run(`BTD_OP_VECTOR, 0, 0, 0, 16'h001f, 0);
		chk(target_addr, 16'h007e);
		run(`BTD_OP_REL, 0, 0, 0, 16'h1000, 8'hfe);
		chk(target_addr, 16'h0ffe);
		run(`BTD_OP_REL, 0, 0, 0, 16'h1000, 8'h7f);
		chk(target_addr, 16'h107f);
	end
	endtask
	task t_bank;
	begin
		chk(register_bank_number, 0);
		for (i = 3; i >= 0; i = i - 1) begin
			run(`BTD_OP_SEL_BANK, 0, 0, 0, 0, i[7:0]);
			chk(register_bank_number, i[1:0]);
		end
	end
	endtask
	// reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(negedge clk);
		sys_rst = 0;
		t_regs;
		t_flags;
		t_index;
		t_refuse;
		t_targets;
		t_bank;
		close_out;
	end
endmodule // tb_byte_transfer_insn_decode
`default_nettype wire
